/* common/bms_regs.vh */
/*
  Constants of the bit-mask set and test unit: operation and mode codes,
  field widths, cycle counts and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BMS_REGS_VH
`define BMS_REGS_VH

// Operation codes on i_op
`define BMS_OP_MEM_SET   2'h0
`define BMS_OP_REG_TSET  2'h1
// Memory address modes on i_mode
`define BMS_MODE_SP_SHORT 2'h0
`define BMS_MODE_SP_LONG  2'h1
`define BMS_MODE_PTR      2'h2
`define BMS_MODE_ABS      2'h3
// Field widths
`define BMS_MASK_W       16
`define BMS_SOFF_W       5
`define BMS_SEL_W        4
`define BMS_PTR_W        3
// Register select: bit 3 chooses the address bank
`define BMS_SEL_ADDR_BIT 3
// Instruction words and cycles per mode
`define BMS_WORDS_SP_SHORT 2'h2
`define BMS_WORDS_SP_LONG  2'h3
`define BMS_WORDS_PTR      2'h2
`define BMS_WORDS_ABS      2'h3
`define BMS_WORDS_REG      2'h2
`define BMS_CYC_SP_SHORT   2'h3
`define BMS_CYC_SP_LONG    2'h3
`define BMS_CYC_PTR        2'h2
`define BMS_CYC_ABS        2'h2
`define BMS_CYC_REG        2'h2
// Reset values
`define BMS_RST_WORD     32'h0000_0000
`define BMS_RST_FLAG     1'h0

`endif

/* logic/bms_addr_gen.v */
/*
  Target address former for the memory bit-set operation.
  Assumes pointer and stack values are presented by the register file and
  stay stable while i_start is seen.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bms_regs.vh"

module bms_addr_gen #(
  parameter AW = 32
) (
  input wire [1:0] i_mode,
  input wire i_exception_mode_stack_select,
  input wire [AW-1:0] i_normal_sp,
  input wire [AW-1:0] i_exception_sp,
  input wire [AW-1:0] i_pointer_register,
  input wire [`BMS_SOFF_W-1:0] i_short_stack_offset,
  input wire [15:0] i_long_signed_stack_offset,
  input wire [15:0] i_absolute_word_address,
  output reg [AW-1:0] o_addr
);

  wire [AW-1:0] active_stack_pointer;
  wire [AW-1:0] soff_ext;
  wire [AW-1:0] loff_ext;
  wire [AW-1:0] abs_ext;

  // Only the exception-mode bit steers the choice of stack
  assign active_stack_pointer = i_exception_mode_stack_select ? i_exception_sp : i_normal_sp;
  assign soff_ext = {{(AW-`BMS_SOFF_W){1'b0}}, i_short_stack_offset};
  assign loff_ext = {{(AW-16){i_long_signed_stack_offset[15]}}, i_long_signed_stack_offset};
  assign abs_ext = {{(AW-16){1'b0}}, i_absolute_word_address};

  always @*
  begin
    case (i_mode)
      `BMS_MODE_SP_SHORT: o_addr = active_stack_pointer - soff_ext;
      `BMS_MODE_SP_LONG: o_addr = active_stack_pointer + loff_ext;
      `BMS_MODE_PTR: o_addr = i_pointer_register;
      default: o_addr = abs_ext;
    endcase
  end

endmodule // bms_addr_gen
`default_nettype wire

/* logic/bms_mask_alu.v */
/*
  Mask set and all-set test on one 16-bit operand.
  Assumes a purely combinational use inside the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bms_regs.vh"

module bms_mask_alu (
  input wire [`BMS_MASK_W-1:0] i_operand,
  input wire [`BMS_MASK_W-1:0] i_immediate_mask,
  output wire [`BMS_MASK_W-1:0] o_result,
  output wire o_all_set
);

  assign o_result = i_operand | i_immediate_mask;
  assign o_all_set = ((i_operand & i_immediate_mask) == i_immediate_mask);

endmodule // bms_mask_alu
`default_nettype wire

/* logic/bms_unit.v */
/*
  Bit-mask set and test unit: memory bit-set by read-modify-write and
  register test-and-set on either half of a data or address register.
  Assumes the core decodes the instruction into the fields below, holds them
  stable while o_busy is high, and owns the register file and status word.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bms_regs.vh"

module bms_unit #(
  parameter AW = 32,
  parameter DW = 40
) (
  input wire i_clk,
  input wire i_sys_rst,
  // Decoded instruction
  input wire i_start,
  input wire [1:0] i_op,
  input wire [1:0] i_mode,
  input wire [`BMS_MASK_W-1:0] i_immediate_mask,
  input wire [`BMS_SOFF_W-1:0] i_short_stack_offset,
  input wire [15:0] i_long_signed_stack_offset,
  input wire [15:0] i_absolute_word_address,
  input wire [`BMS_PTR_W-1:0] i_three_bit_pointer_field,
  input wire [`BMS_SEL_W-1:0] i_four_bit_reg_select_field,
  input wire i_high_prefix,
  input wire i_upper_half_word,
  // Core state
  input wire i_exception_mode_stack_select,
  input wire [AW-1:0] i_normal_sp,
  input wire [AW-1:0] i_exception_sp,
  // Register file read port, index 0..15 per bank
  output wire o_rf_is_addr,
  output wire [3:0] o_rf_index,
  input wire [DW-1:0] i_rf_rdata,
  // Register file write port
  output reg o_rf_we,
  output reg o_rf_we_is_addr,
  output reg [3:0] o_rf_we_index,
  output reg [DW-1:0] o_rf_wdata,
  output reg o_limit_tag_bit_clr,
  // Status true flag update
  output reg o_true_flag_we,
  output reg o_true_flag,
  // Data memory
  output reg o_mem_rd,
  output reg o_mem_wr,
  output reg [AW-1:0] o_mem_addr,
  output reg [15:0] o_mem_wdata,
  input wire i_mem_rvalid,
  input wire [15:0] i_mem_rdata,
  // Operation status
  output wire o_busy,
  output reg o_done,
  output reg [1:0] o_words,
  output reg [1:0] o_cycles
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_RD = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_WR = 4'b1000;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [AW-1:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [`BMS_MASK_W-1:0] mask_reg;

  wire [AW-1:0] calc_addr;
  wire [15:0] reg_half;
  wire [15:0] reg_result;
  wire reg_all_set;
  wire [15:0] mem_result;

  // Register select decode, shared by the pointer and operand paths
  function [4:0] bms_sel;
    input [3:0] field;
    input high;
    begin
      bms_sel = {field[`BMS_SEL_ADDR_BIT], high, field[2:0]};
    end
  endfunction

  wire [4:0] dst_sel;
  wire [4:0] ptr_sel;
  wire use_ptr_port;

  assign dst_sel = bms_sel(i_four_bit_reg_select_field, i_high_prefix);
  assign ptr_sel = bms_sel({1'b1, i_three_bit_pointer_field}, i_high_prefix);
  assign use_ptr_port = (i_op == `BMS_OP_MEM_SET) && (i_mode == `BMS_MODE_PTR);

  // Other op codes are ignored, so a stray start leaves the unit idle
  wire start_mem;
  wire start_reg;
  assign start_mem = i_start && (i_op == `BMS_OP_MEM_SET);
  assign start_reg = i_start && (i_op == `BMS_OP_REG_TSET);

  // One read port serves the pointer register and the destination operand
  assign o_rf_is_addr = use_ptr_port ? ptr_sel[4] : dst_sel[4];
  assign o_rf_index = use_ptr_port ? ptr_sel[3:0] : dst_sel[3:0];

  //////////////////////////////////////////////////////////////////////////

  bms_addr_gen #(
    .AW(AW)
  ) u_addr (
    .i_mode(i_mode),
    .i_exception_mode_stack_select(i_exception_mode_stack_select),
    .i_normal_sp(i_normal_sp),
    .i_exception_sp(i_exception_sp),
    .i_pointer_register(i_rf_rdata[AW-1:0]),
    .i_short_stack_offset(i_short_stack_offset),
    .i_long_signed_stack_offset(i_long_signed_stack_offset),
    .i_absolute_word_address(i_absolute_word_address),
    .o_addr(calc_addr)
  );

  assign reg_half = i_upper_half_word ? i_rf_rdata[31:16] : i_rf_rdata[15:0];

  bms_mask_alu u_reg_alu (
    .i_operand(reg_half),
    .i_immediate_mask(i_immediate_mask),
    .o_result(reg_result),
    .o_all_set(reg_all_set)
  );

  // Mask is captured at start so the write-back does not lean on the decoder
  bms_mask_alu u_mem_alu (
    .i_operand(i_mem_rdata),
    .i_immediate_mask(mask_reg),
    .o_result(mem_result),
    .o_all_set()
  );

  //////////////////////////////////////////////////////////////////////////

  assign o_busy = (state_reg != ST_IDLE);

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start_mem)
          state_next = ST_RD;
      end
      ST_RD: state_next = ST_WAIT;
      ST_WAIT:
      begin
        // Write waits for the read data, so a slow memory only stretches time
        if (i_mem_rvalid)
          state_next = ST_WR;
      end
      ST_WR: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg <= ST_IDLE;
      addr_reg <= {AW{1'b0}};
      wdata_reg <= 16'h0000;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_addr <= {AW{1'b0}};
      o_mem_wdata <= 16'h0000;
      mask_reg <= {`BMS_MASK_W{1'b0}};
      o_done <= 1'b0;
      o_words <= 2'h0;
      o_cycles <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_done <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_mem)
          begin
            addr_reg <= calc_addr;
            mask_reg <= i_immediate_mask;
            case (i_mode)
              `BMS_MODE_SP_SHORT:
              begin
                o_words <= `BMS_WORDS_SP_SHORT;
                o_cycles <= `BMS_CYC_SP_SHORT;
              end
              `BMS_MODE_SP_LONG:
              begin
                o_words <= `BMS_WORDS_SP_LONG;
                o_cycles <= `BMS_CYC_SP_LONG;
              end
              `BMS_MODE_PTR:
              begin
                o_words <= `BMS_WORDS_PTR;
                o_cycles <= `BMS_CYC_PTR;
              end
              default:
              begin
                o_words <= `BMS_WORDS_ABS;
                o_cycles <= `BMS_CYC_ABS;
              end
            endcase
          end
          else if (start_reg)
          begin
            o_done <= 1'b1;
            o_words <= `BMS_WORDS_REG;
            o_cycles <= `BMS_CYC_REG;
          end
        end
        ST_RD:
        begin
          o_mem_rd <= 1'b1;
          o_mem_addr <= addr_reg;
        end
        ST_WAIT:
        begin
          if (i_mem_rvalid)
            wdata_reg <= mem_result;
        end
        ST_WR:
        begin
          o_mem_wr <= 1'b1;
          o_mem_addr <= addr_reg;
          o_mem_wdata <= wdata_reg;
          o_done <= 1'b1;
        end
        default:
        begin
          o_done <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // Register write-back never waits; it starts only while the memory sequencer is in ST_IDLE
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_rf_we <= 1'b0;
      o_rf_we_is_addr <= 1'b0;
      o_rf_we_index <= 4'h0;
      o_rf_wdata <= {DW{1'b0}};
      o_limit_tag_bit_clr <= 1'b0;
      o_true_flag_we <= 1'b0;
      o_true_flag <= `BMS_RST_FLAG;
    end
    else
    begin
      o_rf_we <= 1'b0;
      o_limit_tag_bit_clr <= 1'b0;
      o_true_flag_we <= 1'b0;
      if (start_reg && (state_reg == ST_IDLE))
      begin
        o_rf_we <= 1'b1;
        o_rf_we_is_addr <= dst_sel[4];
        o_rf_we_index <= dst_sel[3:0];
        if (i_upper_half_word)
          o_rf_wdata <= {i_rf_rdata[DW-1:32], reg_result, i_rf_rdata[15:0]};
        else
          o_rf_wdata <= {i_rf_rdata[DW-1:16], reg_result};
        o_true_flag_we <= 1'b1;
        o_true_flag <= reg_all_set;
        // Only data registers carry a limit tag
        o_limit_tag_bit_clr <= ~dst_sel[4];
      end
    end
  end

endmodule // bms_unit
`default_nettype wire

/* tb/bms_mem_model.sv */
/* Data memory model for the bit-mask unit.
   Assumes one read in flight; i_delay adds wait cycles. */
`timescale 1ns/1ps
`default_nettype none
module bms_mem_model (
  input wire logic i_clk,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic [31:0] i_mem_addr,
  input wire logic [15:0] i_mem_wdata,
  input wire logic [3:0] i_delay,
  output logic o_mem_rvalid,
  output logic [15:0] o_mem_rdata
);
  logic [15:0] mem [int unsigned];
  logic [31:0] adr;
  int cnt;
  logic pend = 1'b0;
  initial
  begin
    o_mem_rvalid = 1'b0;
    o_mem_rdata = 16'h0;
  end
  // Data outside the valid cycle toggles so a late sample cannot match
  always @(posedge i_clk)
  begin
    o_mem_rvalid <= 1'b0;
    o_mem_rdata <= ~o_mem_rdata;
    if (i_mem_rd)
    begin
      adr = i_mem_addr;
      cnt = i_delay;
      pend = 1'b1;
    end
    if (pend && cnt == 0)
    begin
      o_mem_rvalid <= 1'b1;
      o_mem_rdata <= mem[adr];
      pend = 1'b0;
    end
    else if (pend)
      cnt = cnt - 1;
    if (i_mem_wr)
      mem[i_mem_addr] = i_mem_wdata;
  end
endmodule // bms_mem_model
`default_nettype wire

/* tb/bms_unit_checker.sv */
/* Checker on the ports of bms_unit.
   Assumes the core clock and its sync reset. */
`timescale 1ns/1ps
`default_nettype none
module bms_unit_checker #(
  parameter AW = 32,
  parameter DW = 40
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [1:0] i_op,
  input wire logic [15:0] i_immediate_mask,
  input wire logic [3:0] i_four_bit_reg_select_field,
  input wire logic i_high_prefix,
  input wire logic i_upper_half_word,
  input wire logic [DW-1:0] i_rf_rdata,
  input wire logic i_mem_rvalid,
  input wire logic [15:0] i_mem_rdata,
  input wire logic o_busy,
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic [AW-1:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata,
  input wire logic o_rf_we,
  input wire logic o_rf_we_is_addr,
  input wire logic [3:0] o_rf_we_index,
  input wire logic [DW-1:0] o_rf_wdata,
  input wire logic o_limit_tag_bit_clr,
  input wire logic o_true_flag_we,
  input wire logic o_true_flag
);
  wire logic ms = i_start && i_op == 2'h0 && !o_busy;
  wire logic ts = i_start && i_op == 2'h1 && !o_busy;
  wire logic [15:0] hw = i_upper_half_word ? i_rf_rdata[31:16] : i_rf_rdata[15:0];
  wire logic al = &(hw | ~i_immediate_mask);
  wire logic [DW-1:0] nv = i_upper_half_word ?
    {i_rf_rdata[DW-1:32], hw | i_immediate_mask, i_rf_rdata[15:0]} :
    {i_rf_rdata[DW-1:16], hw | i_immediate_mask};
  wire logic [4:0] ix = {i_four_bit_reg_select_field[3], i_high_prefix,
    i_four_bit_reg_select_field[2:0]};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////
  AST_RD: assert property (ms |-> ##2 o_mem_rd)
    else $error("read late");
  AST_WR: assert property (i_mem_rvalid |-> ##2 o_mem_wr)
    else $error("write late");
  AST_WDATA: assert property (o_mem_wr |-> o_mem_wdata ==
    ($past(i_mem_rdata, 2) | $past(i_immediate_mask, 2))) else $error("write data");
  AST_WADDR: assert property (o_mem_wr |-> o_mem_addr == $past(o_mem_addr, 2))
    else $error("write address");
  AST_TFLAG: assert property (ts |=> o_true_flag_we && o_true_flag == $past(al))
    else $error("true flag");
  AST_TDATA: assert property (ts |=> o_rf_we && o_rf_wdata == $past(nv))
    else $error("register data");
  AST_TIDX: assert property (ts |=> {o_rf_we_is_addr, o_rf_we_index} == $past(ix))
    else $error("register index");
  AST_LTAG: assert property (o_rf_we |-> o_limit_tag_bit_clr == !o_rf_we_is_addr)
    else $error("limit tag");
  cover property (o_mem_wr);
  cover property (o_true_flag_we && o_true_flag);
  cover property (o_limit_tag_bit_clr);
endmodule // bms_unit_checker
bind bms_unit bms_unit_checker #(.AW(AW), .DW(DW)) u_chk (.i_clk, .i_sys_rst, .i_start,
  .i_op, .i_immediate_mask, .i_four_bit_reg_select_field, .i_high_prefix,
  .i_upper_half_word, .i_rf_rdata, .i_mem_rvalid, .i_mem_rdata, .o_busy, .o_mem_rd,
  .o_mem_wr, .o_mem_addr, .o_mem_wdata, .o_rf_we, .o_rf_we_is_addr, .o_rf_we_index,
  .o_rf_wdata, .o_limit_tag_bit_clr, .o_true_flag_we, .o_true_flag);
`default_nettype wire

/* tb/tb_top.sv */
/* Testbench for bms_unit: memory set in all modes, register test-and-set.
   Assumes the memory model and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam logic [31:0] NSP = 32'h0000_1000;
  localparam logic [31:0] ESP = 32'h0000_2000;
  logic clk = 0, rst = 1, st = 0, hp = 0, up = 0, exc = 0;
  logic [1:0] op = 0, md = 0;
  logic [3:0] sel = 0, dly = 0, rf_ix, we_ix;
  logic [15:0] msk = 0, x = 0, mwd, mrdt;
  logic [39:0] rf [0:31];
  logic [39:0] wd;
  logic [31:0] ma;
  logic [1:0] wds, cyc;
  logic rf_a, we, we_a, ltc, tfw, tf, mrd, mwr, rv, busy, done;
  int num_errors = 0, n_tests = 0, nacc = 0;
  bms_unit u_dut (.i_clk(clk), .i_sys_rst(rst), .i_start(st), .i_op(op), .i_mode(md),
    .i_immediate_mask(msk), .i_short_stack_offset(x[4:0]), .i_long_signed_stack_offset(x),
    .i_absolute_word_address(x), .i_three_bit_pointer_field(x[2:0]),
    .i_four_bit_reg_select_field(sel), .i_high_prefix(hp), .i_upper_half_word(up),
    .i_exception_mode_stack_select(exc), .i_normal_sp(NSP), .i_exception_sp(ESP),
    .o_rf_is_addr(rf_a), .o_rf_index(rf_ix), .i_rf_rdata(rf[{rf_a, rf_ix}]),
    .o_rf_we(we), .o_rf_we_is_addr(we_a), .o_rf_we_index(we_ix), .o_rf_wdata(wd),
    .o_limit_tag_bit_clr(ltc), .o_true_flag_we(tfw), .o_true_flag(tf), .o_mem_rd(mrd),
    .o_mem_wr(mwr), .o_mem_addr(ma), .o_mem_wdata(mwd), .i_mem_rvalid(rv),
    .i_mem_rdata(mrdt), .o_busy(busy), .o_done(done), .o_words(wds), .o_cycles(cyc));
  bms_mem_model u_mem (.i_clk(clk), .i_mem_rd(mrd), .i_mem_wr(mwr), .i_mem_addr(ma),
    .i_mem_wdata(mwd), .i_delay(dly), .o_mem_rvalid(rv), .o_mem_rdata(mrdt));
  always #2.5 clk = ~clk;
  // Register file behind the unit; accesses are counted to catch extra ones
  always @(posedge clk)
  begin
    if (we)
      rf[{we_a, we_ix}] <= wd;
    nacc <= nacc + mrd + mwr + we;
  end
  ////////////////////////////////////////////////////////////////
  task automatic mset(input logic [1:0] m, input logic e, input logic [15:0] xv, mk, v,
    input logic [3:0] d);
    logic [31:0] a;
    int n, a0;
    case (m)
      2'h0: a = (e ? ESP : NSP) - xv[4:0];
      2'h1: a = (e ? ESP : NSP) + {{16{xv[15]}}, xv};
      2'h2: a = rf[{1'b1, xv[3:0]}][31:0];
      default: a = {16'h0, xv};
    endcase
    u_mem.mem[a] = v;
    @(posedge clk);
    {op, md, exc, x, hp, msk, dly} <= {2'h0, m, e, xv, xv[3], mk, d};
    st <= 1'b1;
    @(posedge clk);
    st <= 1'b0;
    #1 a0 = nacc;
    for (n = 0; n < 40 && mrd !== 1'b1; n++)
      @(posedge clk) #1;
    `CHK({mrd, busy, ma}, {2'h3, a})
    for (n = 0; n < 40 && mwr !== 1'b1; n++)
      @(posedge clk) #1;
    `CHK({mwr, busy, ma}, {2'h2, a})
    `CHK(mwd, v | mk)
    `CHK({done, wds, cyc}, {1'b1, m[0] ? 2'h3 : 2'h2, m[1] ? 2'h2 : 2'h3})
    repeat (3) @(posedge clk);
    #1 `CHK(nacc - a0, 2)
  endtask
  task automatic tset(input logic [3:0] s, input logic h, u, input logic [15:0] mk);
    logic [39:0] old, nw;
    logic [15:0] hw;
    @(posedge clk);
    {op, sel, hp, up, msk} <= {2'h1, s, h, u, mk};
    st <= 1'b1;
    #1 old = rf[{s[3], h, s[2:0]}];
    hw = u ? old[31:16] : old[15:0];
    nw = old;
    if (u)
      nw[31:16] = hw | mk;
    else
      nw[15:0] = hw | mk;
    @(posedge clk);
    st <= 1'b0;
    #1 `CHK({we, tfw, done, wd}, {3'h7, nw})
    `CHK(tf, (hw & mk) == mk)
    `CHK({ltc, we_a, we_ix}, {~s[3], s[3], h, s[2:0]})
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 32; i++)
      rf[i] = {5{8'(i * 2)}}; // Even pointers only
    rf[1] = 40'h00_1234_5678;
    rf[4] = 40'h00_1234_5678;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    mset(2'h0, 1'b0, 16'h001e, 16'h0f0f, 16'h1234, 4'h0);
    mset(2'h0, 1'b1, 16'h0002, 16'h8000, 16'h0001, 4'h2);
    mset(2'h1, 1'b1, 16'hfff0, 16'hffff, 16'h0000, 4'h1);
    mset(2'h1, 1'b0, 16'h0100, 16'h00ff, 16'hff00, 4'h0);
    mset(2'h2, 1'b1, 16'h000d, 16'h0003, 16'h8001, 4'h3);
    mset(2'h2, 1'b0, 16'h0002, 16'h0000, 16'h5a5a, 4'h0);
    mset(2'h3, 1'b1, 16'h800c, 16'hf111, 16'hc642, 4'h0);
    tset(4'h1, 1'b0, 1'b0, 16'h111f);
    tset(4'h4, 1'b0, 1'b0, 16'h4238);
    tset(4'ha, 1'b1, 1'b1, 16'h00ff);
    tset(4'h7, 1'b1, 1'b1, 16'h0000);
    tset(4'h1, 1'b0, 1'b1, 16'hffff);
    end_sim;
  end
  initial
  begin
    #20000;
    num_errors++;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
